// *** lock_ack_front_end.sv ***
// Port front end: lock steering, enable gating, acknowledges, test counters
`timescale 1ns/100ps
module lock_ack_front_end (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic lock_n,
  input wire logic [1:0] rd_n,
  input wire logic [1:0] wr_n,
  input wire logic [1:0] port_enable_n,
  input wire logic refresh_req,
  input wire logic ecc_mode,
  input wire logic cycle_class_select,
  input wire logic port_a_sync_select,
  input wire logic port_b_sync_select,
  input wire logic [1:0] transfer_acknowledge_select,
  input wire logic fast_ram,
  input wire logic extend,
  input wire logic test_mode1,
  input wire logic test_mode2,
  output logic port_select_output,
  output logic ras_n,
  output logic [1:0] advanced_acknowledge_n,
  output logic [1:0] transfer_acknowledge_n,
  output logic data_valid,
  output logic init_active,
  output logic [lock_ack_pkg::REFRESH_W-1:0] ram_address_out
);
  import lock_ack_pkg::*;

  // =====================================================================
  // Input synchronisers
  logic [1:0] rd_s1_q, rd_s2_q, wr_s1_q, wr_s2_q, pe_s1_q, pe_s2_q;
  logic lock_s1_q, lock_s2_q, rfq_s1_q, rfq_s2_q;
  logic [1:0] rd_x_q, wr_x_q, pe_x_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_s1_q <= 2'h3;
      rd_s2_q <= 2'h3;
    end else begin
      rd_s1_q <= rd_n;
      rd_s2_q <= rd_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_s1_q <= 2'h3;
      wr_s2_q <= 2'h3;
    end else begin
      wr_s1_q <= wr_n;
      wr_s2_q <= wr_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pe_s1_q <= 2'h3;
      pe_s2_q <= 2'h3;
    end else begin
      pe_s1_q <= port_enable_n;
      pe_s2_q <= pe_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lock_s1_q <= 1'b1;
      lock_s2_q <= 1'b1;
    end else begin
      lock_s1_q <= lock_n;
      lock_s2_q <= lock_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rfq_s1_q <= 1'b0;
      rfq_s2_q <= 1'b0;
    end else begin
      rfq_s1_q <= refresh_req;
      rfq_s2_q <= rfq_s1_q;
    end
  end

  // Extra stage for asynchronous ports
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_x_q <= 2'h3;
      wr_x_q <= 2'h3;
      pe_x_q <= 2'h3;
    end else begin
      rd_x_q <= rd_s2_q;
      wr_x_q <= wr_s2_q;
      pe_x_q <= pe_s2_q;
    end
  end

  // =====================================================================
  // Request qualification per port
  logic [1:0] sync_sel;
  logic [1:0] req;
  logic [1:0] cmd_act;
  assign sync_sel = {port_b_sync_select, port_a_sync_select};

  // Read or write command active
  function automatic logic cmd_active(input logic rd, input logic wr);
    return !rd || !wr;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_req
      // Sync ports use the earlier stage; async ports one stage later
      assign cmd_act[g] = sync_sel[g] ? cmd_active(rd_s2_q[g], wr_s2_q[g])
                                      : cmd_active(rd_x_q[g], wr_x_q[g]);
      assign req[g] = sync_sel[g] ? (cmd_act[g] && !pe_s2_q[g])
                                  : (cmd_act[g] && !pe_x_q[g]);
    end
  endgenerate

  // =====================================================================
  // Arbiter, lock and RAM cycle timing
  cyc_state_e state_q;
  logic sel_q, locked_q, lock_port_q;
  logic [2:0] ras_cnt_q;
  logic [1:0] done_q;
  logic lock_act;
  assign lock_act = !lock_s2_q;

  // Lock owner: port A when high, B when low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      locked_q <= 1'b0;
      lock_port_q <= 1'b1;
    end else begin
      if (lock_act && !locked_q && state_q != ST_REFRESH) begin
        locked_q <= 1'b1;
        lock_port_q <= sel_q;
      end else if (!lock_act) begin
        locked_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      sel_q <= 1'b1;
      ras_cnt_q <= 3'h0;
      done_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!cmd_act[i]) begin
          done_q[i] <= 1'b0;
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (rfq_s2_q) begin
            state_q <= ST_REFRESH;
            ras_cnt_q <= RAS_LEN;
          end else if (locked_q) begin
            sel_q <= lock_port_q;
            if (req[~lock_port_q] && !done_q[~lock_port_q]) begin
              state_q <= ST_CYCLE;
              ras_cnt_q <= RAS_LEN;
            end
          end else if (req[~sel_q] && !done_q[~sel_q]) begin
            state_q <= ST_CYCLE;
            ras_cnt_q <= RAS_LEN;
          end else if (req[sel_q] && !done_q[sel_q]) begin
            sel_q <= !sel_q;
          end
        end
        ST_CYCLE: begin
          if (ras_cnt_q == 3'h1) begin
            state_q <= ST_IDLE;
            done_q[~sel_q] <= 1'b1;
          end
          ras_cnt_q <= ras_cnt_q - 3'h1;
        end
        ST_REFRESH: begin
          if (ras_cnt_q == 3'h1) begin
            state_q <= ST_IDLE;
          end
          ras_cnt_q <= ras_cnt_q - 3'h1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Served port index: high select is port A (index 0)
  logic srv;
  assign srv = ~sel_q;
  logic cyc_start;
  assign cyc_start = (state_q == ST_CYCLE) && (ras_cnt_q == RAS_LEN);

  // =====================================================================
  // Acknowledge generation
  logic [2:0] ack_len;
  logic fast_delay;
  assign ack_len = cycle_class_select ? ACK_LEN_FAST : ACK_LEN_SLOW;
  // Fast class with fast RAM and no extend waits half a clock, modelled as one clock here
  assign fast_delay = cycle_class_select && fast_ram && !extend;
  logic [2:0] dly_q[2];
  logic [2:0] len_q[2];
  logic [1:0] advanced_acknowledge_q, transfer_acknowledge_q, xpend_q, dv_q, advanced_acknowledge_en;

  // ECC keeps a single strobe: type set by select bit
  assign advanced_acknowledge_en = ~({2{ecc_mode}} & transfer_acknowledge_select);

  // Delay and width counters per port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        dly_q[i] <= 3'h0;
        len_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cyc_start && srv == i[0]) begin
          // Early for sync, late for async
          dly_q[i] <= (sync_sel[i] ? 3'h0 : LATE_DELAY) + (fast_delay ? 3'h1 : 3'h0);
          len_q[i] <= ack_len;
        end else if (dly_q[i] != 3'h0) begin
          dly_q[i] <= dly_q[i] - 3'h1;
        end else if (len_q[i] != 3'h0) begin
          len_q[i] <= len_q[i] - 3'h1;
        end
      end
    end
  end

  // Timing pulse, kept even where the strobe is suppressed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      advanced_acknowledge_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        advanced_acknowledge_q[i] <= (dly_q[i] == 3'h0) && (len_q[i] != 3'h0);
      end
    end
  end

  // Data valid a fixed delay after the pulse
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dv_q <= 2'h0;
    end else begin
      dv_q <= advanced_acknowledge_q;
    end
  end

  // Transfer acknowledge armed at cycle start, cleared with command
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      transfer_acknowledge_q <= 2'h0;
      xpend_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!cmd_act[i]) begin
          transfer_acknowledge_q[i] <= 1'b0;
          xpend_q[i] <= 1'b0;
        end else if (cyc_start && srv == i[0]) begin
          xpend_q[i] <= 1'b1;
        end else if (xpend_q[i] && advanced_acknowledge_q[i]) begin
          transfer_acknowledge_q[i] <= !ecc_mode || transfer_acknowledge_select[i];
        end
      end
    end
  end

  // Hold read data while the sync command is active; async host latches it
  logic data_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_q <= 1'b0;
    end else begin
      data_q <= (dv_q != 2'h0) || (data_q && cmd_act[srv] && sync_sel[srv]);
    end
  end

  // =====================================================================
  // Refresh counter and test modes
  logic [REFRESH_W-1:0] rcnt_q;
  logic refr_upd, init_q, tm_seen_q;
  assign refr_upd = (state_q == ST_REFRESH) && (ras_cnt_q == 3'h1);

  // First clock after reset samples the test modes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tm_seen_q <= 1'b0;
    end else begin
      tm_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= REFRESH_RESET;
      init_q <= 1'b1;
    end else begin
      if (!tm_seen_q && test_mode2 && ecc_mode) begin
        rcnt_q <= REFRESH_PRESET;
        init_q <= 1'b0;
      end else if (!tm_seen_q && (test_mode1 || !ecc_mode)) begin
        init_q <= 1'b0;
      end else if (refr_upd) begin
        if (test_mode1) begin
          rcnt_q[HALF_W-1:0] <= rcnt_q[HALF_W-1:0] + 1'b1;
          rcnt_q[REFRESH_W-1:HALF_W] <= rcnt_q[REFRESH_W-1:HALF_W] + 1'b1;
        end else begin
          rcnt_q <= rcnt_q + 1'b1;
          if (rcnt_q == {REFRESH_W{1'b1}}) begin
            init_q <= 1'b0;
          end
        end
      end
    end
  end

  // =====================================================================
  // Registered outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_select_output <= 1'b1;
    end else begin
      port_select_output <= sel_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ras_n <= 1'b1;
    end else begin
      ras_n <= (state_q == ST_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      advanced_acknowledge_n <= 2'h3;
    end else begin
      advanced_acknowledge_n <= ~(advanced_acknowledge_q & advanced_acknowledge_en);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      transfer_acknowledge_n <= 2'h3;
    end else begin
      transfer_acknowledge_n <= ~(transfer_acknowledge_q & cmd_act);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= data_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_active <= 1'b1;
    end else begin
      init_active <= init_q && ecc_mode && !test_mode1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ram_address_out <= REFRESH_RESET;
    end else begin
      ram_address_out <= rcnt_q;
    end
  end
endmodule

// *** lock_ack_pkg.sv ***
// Constants and types for the dual-port lock and acknowledge front end
// =====================================================================
package lock_ack_pkg;
  localparam int REFRESH_W = 9;
  localparam int HALF_W = 5;
  localparam logic [8:0] REFRESH_RESET = 9'h000;
  localparam logic [8:0] REFRESH_PRESET = 9'h1FC;
  localparam logic [2:0] ACK_LEN_FAST = 3'h3;
  localparam logic [2:0] ACK_LEN_SLOW = 3'h2;
  localparam logic [2:0] LATE_DELAY = 3'h2;
  localparam logic [2:0] DATA_DELAY = 3'h1;
  localparam logic [2:0] RAS_LEN = 3'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CYCLE = 2'b01,
    ST_REFRESH = 2'b10
  } cyc_state_e;
endpackage

// *** lock_ack_front_end_sva.sv ***
// Assertions for the lock and acknowledge front end
`timescale 1ns/100ps
module lock_ack_front_end_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic lock_n,
  input wire logic [1:0] rd_n,
  input wire logic [1:0] wr_n,
  input wire logic ecc_mode,
  input wire logic cycle_class_select,
  input wire logic port_a_sync_select,
  input wire logic [1:0] transfer_acknowledge_select,
  input wire logic port_select_output,
  input wire logic ras_n,
  input wire logic [1:0] advanced_acknowledge_n,
  input wire logic [1:0] transfer_acknowledge_n,
  input wire logic data_valid
);
  // ====
  // Acknowledge and lock checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_fall; $fell(advanced_acknowledge_n[0]); endsequence
  sequence s_ack3; !advanced_acknowledge_n[0] [*3] ##1 advanced_acknowledge_n[0]; endsequence
  sequence s_ack2; !advanced_acknowledge_n[0] [*2] ##1 advanced_acknowledge_n[0]; endsequence
  sequence s_locked; !lock_n [*6]; endsequence
  sequence s_transfer_acknowledge_on; !transfer_acknowledge_n[0] && !(rd_n[0] && wr_n[0]); endsequence
  sequence s_cmd_off; $rose(rd_n[0] & wr_n[0]); endsequence
  sequence s_b_idle; advanced_acknowledge_n[1] && transfer_acknowledge_n[1]; endsequence
  a_ack_fast_width: assert property (s_fall ##0 cycle_class_select |-> s_ack3)
    else $error("fast ack width");
  a_ack_slow_width: assert property (s_fall ##0 !cycle_class_select |-> s_ack2)
    else $error("slow ack width");
  a_data_after_ack: assert property (s_fall ##0 !rd_n[0] |-> ##2 data_valid)
    else $error("data not valid after ack");
  a_ack_in_ras: assert property (s_fall ##0 port_a_sync_select |-> !ras_n)
    else $error("early ack outside row strobe");
  a_transfer_acknowledge_hold: assert property (s_transfer_acknowledge_on |=> !transfer_acknowledge_n[0])
    else $error("transfer_acknowledge dropped early");
  a_transfer_acknowledge_release: assert property (s_cmd_off |-> ##[0:5] transfer_acknowledge_n[0])
    else $error("transfer_acknowledge kept after release");
  a_lock_keeps_sel: assert property (s_locked |-> $stable(port_select_output))
    else $error("select moved while locked");
  a_lock_blocks_b: assert property (s_locked ##0 port_select_output |-> s_b_idle)
    else $error("b served");
  a_ecc_one_ack: assert property (ecc_mode && transfer_acknowledge_select[0] |-> advanced_acknowledge_n[0])
    else $error("advanced ack in transfer_acknowledge mode");
endmodule

// *** lock_ack_host_model.sv ***
// Host model: one processor port issuing read or write cycles
`timescale 1ns/100ps
module lock_ack_host_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic go,
  input wire logic pe_on,
  input wire logic wr,
  input wire logic [1:0] ack_n,
  output logic [1:0] cmd_n,
  output logic pe_n,
  output logic done,
  output logic got
);
  int cnt;
  // ====
  // Command, enable and wait for acknowledge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_n <= 2'h3;
      pe_n <= 1'b1;
      done <= 1'b0;
      got <= 1'b0;
      cnt <= 0;
    end else begin
      done <= 1'b0;
      if (go && cnt == 0) begin
        cmd_n <= {!wr, wr};
        pe_n <= !pe_on;
        got <= 1'b0;
        cnt <= 1;
      end else if (cnt > 0) begin
        cnt <= cnt + 1;
        if (ack_n != 2'h3) got <= 1'b1;
        if (!ack_n[1] || cnt == 24) begin
          cmd_n <= 2'h3;
          pe_n <= 1'b1;
          cnt <= 0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// *** lock_ack_front_end_tb.sv ***
// Self-checking testbench for the lock and acknowledge front end
`timescale 1ns/100ps
module lock_ack_front_end_tb;
  import lock_ack_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, lock_n = 1'b1, refresh_req = 1'b0, ecc_mode = 1'b0;
  logic cycle_class_select = 1'b0, port_a_sync_select = 1'b1, port_b_sync_select = 1'b0;
  logic fast_ram = 1'b0, extend = 1'b0, test_mode1 = 1'b0, test_mode2 = 1'b0;
  logic [1:0] transfer_acknowledge_select = 2'h0, go = 2'h0, pe_on = 2'h0, wr = 2'h0;
  logic port_select_output, ras_n, data_valid, init_active;
  logic [1:0] advanced_acknowledge_n, transfer_acknowledge_n;
  logic [REFRESH_W-1:0] ram_address_out, adr;
  wire [1:0] rd_n, wr_n, port_enable_n, done, got;
  logic q[2][$];
  int mismatches = 0, n_checks = 0;
  always #10 mclk = ~mclk;
  lock_ack_front_end uut (.*);
  for (genvar p = 0; p < 2; p++) begin : g_host
    lock_ack_host_model host (.mclk(mclk), .nrst(nrst), .go(go[p]), .pe_on(pe_on[p]),
      .wr(wr[p]), .ack_n({transfer_acknowledge_n[p], advanced_acknowledge_n[p]}),
      .cmd_n({wr_n[p], rd_n[p]}), .pe_n(port_enable_n[p]), .done(done[p]), .got(got[p]));
  end
  // ====
  // Result monitor and helpers
  always @(negedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (done[p] === 1'b1) chk(9'(got[p]), 9'(q[p].pop_front()));
    end
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst(input logic [2:0] m);
    @(posedge mclk);
    nrst <= 1'b0;
    {ecc_mode, test_mode1, test_mode2} <= m;
    repeat (5) @(posedge mclk);
    chk(9'({port_select_output, ras_n, data_valid, init_active, advanced_acknowledge_n,
      transfer_acknowledge_n}), 9'h0DF);
    chk(ram_address_out, REFRESH_RESET);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic xfer(input int p, input logic en, input logic exp);
    @(posedge mclk);
    wr[p] <= 1'($urandom);
    pe_on[p] <= en;
    go[p] <= 1'b1;
    q[p].push_back(exp);
    @(posedge mclk);
    go[p] <= 1'b0;
    while (q[p].size() > 0) @(posedge mclk);
    repeat (6) @(posedge mclk);
  endtask
  task automatic refresh(input logic [8:0] exp);
    refresh_req <= 1'b1;
    for (int i = 0; i < 20 && ras_n !== 1'b0; i++) @(posedge mclk);
    refresh_req <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(ram_address_out, exp);
  endtask
  // ====
  // Scenarios
  initial begin
    void'($urandom(14));
    for (int i = 0; i < 4; i++) begin
      cycle_class_select <= i[0];
      port_a_sync_select <= i[1];
      port_b_sync_select <= !i[1];
      fast_ram <= 1'($urandom);
      extend <= 1'($urandom);
      rst(3'h0);
      xfer(0, 1'b1, 1'b1);
      xfer(1, 1'b1, 1'b1);
      xfer(0, 1'b0, 1'b0);
      xfer(1, 1'b0, 1'b0);
    end
    xfer(0, 1'b1, 1'b1);
    lock_n <= 1'b0;
    repeat (6) @(posedge mclk);
    xfer(1, 1'b1, 1'b0);
    xfer(0, 1'b1, 1'b1);
    adr = ram_address_out;
    refresh(adr + 9'h001);
    chk(9'(port_select_output), 9'h001);
    lock_n <= 1'b1;
    xfer(1, 1'b1, 1'b1);
    rst(3'h2);
    chk(9'(init_active), 9'h000);
    adr = ram_address_out;
    refresh({adr[REFRESH_W-1:HALF_W] + 4'h1, adr[HALF_W-1:0] + 5'h01});
    transfer_acknowledge_select <= 2'h1;
    rst(3'h5);
    chk(9'(init_active), 9'h000);
    chk(ram_address_out, REFRESH_PRESET);
    xfer(0, 1'b1, 1'b1);
    xfer(1, 1'b1, 1'b1);
    conclude();
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
bind lock_ack_front_end lock_ack_front_end_sva chk_i (.*);
